// ### hdl/osc_select_pkg.sv
// Summary of operation
// - Erased device boots from postscaled fast RC
// - Range field bits 4:3, erased means above 8 MHz
// - Switching allowed only when upper pair bit zero
// - Fail-safe monitor active only when pair is 00
// - Internal mode decodes codes 111, 110, 101, 001, 000
// - Code 100 with external mode: secondary oscillator
// - Code 011 routes primary through PLL
// - Code 010 selects primary without PLL
// - Current-source field read-only, resets to zero
// - Requested-source field loads from initial config
// - PLL-lock cleared during switch and non-PLL modes
// - Clock-fail flag hardware set, software clear only
// - Switch-freeze software settable only, resets zero
// - Drive-strength ignored with digital secondary input
// - Tuning register shifts RC by fixed steps
// - Switch-request starts switch, hardware clears when done
// - Monitor on plus freeze locks selections
// - PLL-lock reads one when locked or timer expired
// - Monitor failure detection sets clock-fail flag
package osc_select_pkg;
   // Register byte offsets on the bus
   localparam logic [3:0] ADDR_OSC_CTRL = 4'h0;
   localparam logic [3:0] ADDR_CFG_VIEW = 4'h4;
   localparam logic [3:0] ADDR_RC_TUNE = 4'h8;
   // Control register field positions
   localparam int CUR_LO = 12;
   localparam int REQ_LO = 8;
   localparam int FREEZE_BIT = 7;
   localparam int LOCK_BIT = 5;
   localparam int FAIL_BIT = 3;
   localparam int DRIVE_BIT = 2;
   localparam int SEC_EN_BIT = 1;
   localparam int SWITCH_BIT = 0;
   // Configuration word field positions
   localparam int CFG_PMODE_LO = 0;
   localparam int CFG_RANGE_LO = 3;
   localparam int CFG_SECSRC_BIT = 5;
   localparam int CFG_SWMON_LO = 6;
   localparam int CFG_SWEN_BIT = 7;
   // Source selection codes
   localparam logic [2:0] SRC_FAST_RC = 3'h0;
   localparam logic [2:0] SRC_FAST_RC_PLL = 3'h1;
   localparam logic [2:0] SRC_PRIMARY = 3'h2;
   localparam logic [2:0] SRC_PRIMARY_PLL = 3'h3;
   localparam logic [2:0] SRC_SECONDARY = 3'h4;
   localparam logic [2:0] SRC_LOW_POWER_RC = 3'h5;
   localparam logic [2:0] SRC_SLOW_RC_DIV = 3'h6;
   localparam logic [2:0] SRC_FAST_RC_DIV = 3'h7;
   // Primary-mode codes
   localparam logic [1:0] PM_EXTERNAL = 2'h0;
   localparam logic [1:0] PM_STD_CRYSTAL = 2'h1;
   localparam logic [1:0] PM_FAST_CRYSTAL = 2'h2;
   localparam logic [1:0] PM_INTERNAL = 2'h3;
   // Erased and reset values
   localparam logic [1:0] ERASED_PMODE = PM_INTERNAL;
   localparam logic [2:0] ERASED_SOURCE = SRC_FAST_RC_DIV;
   localparam logic [1:0] RANGE_ABOVE_8MHZ = 2'h3;
   localparam logic [1:0] MONITOR_ON_PAIR = 2'h0;
   localparam logic [2:0] CUR_RESET = 3'h0;
   localparam int TUNE_WIDTH = 6;
   localparam logic [TUNE_WIDTH-1:0] TUNE_RESET = 6'h00;
   // Timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int SWITCH_SETTLE_NS = 100;
   localparam logic [3:0] SWITCH_SETTLE_CYCLES = 4'((SWITCH_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam int PLL_START_US = 200;
   localparam logic [15:0] PLL_START_CYCLES_DEF = 16'((PLL_START_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   // Controller states
   typedef enum logic [2:0] {
      ST_POWERUP = 3'b001,
      ST_IDLE = 3'b010,
      ST_SWITCH = 3'b100
   } osc_state_type;
endpackage

// ### hdl/oscillator_select_control.sv
`timescale 1ns/1ns
module oscillator_select_control
   import osc_select_pkg::*;
#(
   parameter logic [15:0] PLL_START_CYCLES = PLL_START_CYCLES_DEF
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [3:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   input wire logic [7:0] cfg_osc_i,
   input wire logic [2:0] initial_source_cfg_i,
   input wire logic pll_locked_i,
   input wire logic clock_fail_i,
   output logic [2:0] source_select_o,
   output logic [1:0] primary_mode_o,
   output logic pll_enable_o,
   output logic switching_o,
   output logic secondary_enable_o,
   output logic secondary_high_power_o,
   output logic ext_range_high_o,
   output logic monitor_enable_o,
   output logic [TUNE_WIDTH-1:0] rc_trim_o
);

   typedef struct packed {
      osc_state_type fsm;
      logic [7:0] cfg;
      logic [2:0] init_src;
      logic [2:0] cur;
      logic [2:0] req;
      logic sw_req;
      logic freeze;
      logic fail;
      logic drive;
      logic sec_en;
      logic lock;
      logic [3:0] settle;
      logic [15:0] pll_cnt;
      logic pll_meta;
      logic pll_sync;
      logic fail_meta;
      logic fail_sync;
      logic ack;
      logic [31:0] dat;
      logic [TUNE_WIDTH-1:0] tune;
   } state_type;

   state_type s_r;
   state_type s_nxt;

   // Sources that run the clock through the 4x PLL
   function automatic logic uses_pll(input logic [2:0] src);
      uses_pll = (src == SRC_PRIMARY_PLL) || (src == SRC_FAST_RC_PLL);
   endfunction

   // Legal pairings of source code and primary mode
   function automatic logic combo_valid(input logic [2:0] src, input logic [1:0] pm);
      case (src)
         SRC_PRIMARY_PLL: combo_valid = (pm == PM_FAST_CRYSTAL) || (pm == PM_EXTERNAL);
         SRC_PRIMARY: combo_valid = (pm != PM_INTERNAL);
         SRC_SECONDARY: combo_valid = (pm == PM_EXTERNAL);
         default: combo_valid = (pm == PM_INTERNAL);
      endcase
   endfunction

   logic [1:0] pmode;
   logic monitor_on;
   logic switch_ok;
   logic frozen;
   logic bus_req;
   logic wr_ctrl;
   logic wr_tune;
   logic [15:0] ctrl_word;

   // Decoded configuration and bus qualifiers
   assign pmode = s_r.cfg[CFG_PMODE_LO +: 2];
   assign monitor_on = (s_r.cfg[CFG_SWMON_LO +: 2] == MONITOR_ON_PAIR);
   assign switch_ok = ~s_r.cfg[CFG_SWEN_BIT];
   assign frozen = monitor_on & s_r.freeze;
   assign bus_req = cyc_i & stb_i;
   // Writes land on the edge that samples ack, as the master expects
   assign wr_ctrl = bus_req & we_i & s_r.ack & (adr_i == ADDR_OSC_CTRL);
   assign wr_tune = bus_req & we_i & s_r.ack & (adr_i == ADDR_RC_TUNE);

   // Control register image; unimplemented bits read as zero
   always_comb begin
      ctrl_word = 16'h0000;
      ctrl_word[CUR_LO +: 3] = s_r.cur;
      ctrl_word[REQ_LO +: 3] = s_r.req;
      ctrl_word[FREEZE_BIT] = s_r.freeze;
      ctrl_word[LOCK_BIT] = s_r.lock;
      ctrl_word[FAIL_BIT] = s_r.fail;
      ctrl_word[DRIVE_BIT] = s_r.drive;
      ctrl_word[SEC_EN_BIT] = s_r.sec_en;
      ctrl_word[SWITCH_BIT] = s_r.sw_req;
   end

   // Next-state logic for the whole block
   always_comb begin
      s_nxt = s_r;
      // Two-stage synchronisers for the analog status lines
      s_nxt.pll_meta = pll_locked_i;
      s_nxt.pll_sync = s_r.pll_meta;
      s_nxt.fail_meta = clock_fail_i;
      s_nxt.fail_sync = s_r.fail_meta;

      // Classic bus: one wait state, ack drops the cycle after it was given
      s_nxt.ack = bus_req & ~s_r.ack;
      if (bus_req & ~s_r.ack) begin
         case (adr_i)
            ADDR_OSC_CTRL: s_nxt.dat = {16'h0000, ctrl_word};
            ADDR_CFG_VIEW: s_nxt.dat = {21'h000000, s_r.init_src, s_r.cfg};
            ADDR_RC_TUNE: s_nxt.dat = {26'h0000000, s_r.tune};
            default: s_nxt.dat = 32'h00000000;
         endcase
      end

      // Switch sequencer
      case (s_r.fsm)
         ST_POWERUP: begin
            s_nxt.cur = s_r.init_src;
            s_nxt.fsm = ST_IDLE;
         end
         ST_IDLE: begin
            if (s_r.sw_req) begin
               // Illegal pairings and disabled switching drop the request unserved
               if (switch_ok && combo_valid(s_r.req, pmode)) begin
                  s_nxt.fsm = ST_SWITCH;
                  s_nxt.settle = 4'h0;
               end else begin
                  s_nxt.sw_req = 1'b0;
               end
            end
         end
         ST_SWITCH: begin
            if (s_r.settle == SWITCH_SETTLE_CYCLES - 4'h1) begin
               s_nxt.cur = s_r.req;
               s_nxt.sw_req = 1'b0;
               s_nxt.fsm = ST_IDLE;
            end else begin
               s_nxt.settle = s_r.settle + 4'h1;
            end
         end
         default: s_nxt.fsm = ST_POWERUP;
      endcase

      // PLL start-up timer runs only while a PLL mode is settled in
      if ((s_r.fsm != ST_IDLE) || !uses_pll(s_r.cur)) begin
         s_nxt.pll_cnt = 16'h0000;
      end else if (s_r.pll_cnt != PLL_START_CYCLES) begin
         s_nxt.pll_cnt = s_r.pll_cnt + 16'h0001;
      end
      // Lock shows zero across a switch and in any non-PLL mode
      s_nxt.lock = (s_nxt.fsm == ST_IDLE) && uses_pll(s_nxt.cur)
                   && (s_r.pll_sync || (s_r.pll_cnt == PLL_START_CYCLES));

      // Software writes to the control register
      if (wr_ctrl) begin
         if (sel_i[1] && !frozen) begin
            s_nxt.req = dat_i[REQ_LO +: 3];
         end
         if (sel_i[0]) begin
            if (dat_i[FREEZE_BIT]) begin
               s_nxt.freeze = 1'b1;
            end
            if (!frozen && switch_ok && dat_i[SWITCH_BIT]) begin
               s_nxt.sw_req = 1'b1;
            end
            if (!dat_i[FAIL_BIT]) begin
               s_nxt.fail = 1'b0;
            end
            s_nxt.drive = dat_i[DRIVE_BIT];
            s_nxt.sec_en = dat_i[SEC_EN_BIT];
         end
      end
      if (wr_tune && sel_i[0]) begin
         s_nxt.tune = dat_i[TUNE_WIDTH-1:0];
      end

      // Hardware updates come last so they beat a same-cycle software write
      if (!monitor_on) begin
         s_nxt.freeze = 1'b0;
      end
      if (s_r.fail_sync && monitor_on) begin
         s_nxt.fail = 1'b1;
      end
   end

   // State register; configuration is captured while reset is held
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_r <= '0;
         s_r.fsm <= ST_POWERUP;
         s_r.cfg <= cfg_osc_i;
         s_r.init_src <= initial_source_cfg_i;
         s_r.req <= initial_source_cfg_i;
         s_r.cur <= CUR_RESET;
         s_r.tune <= TUNE_RESET;
      end else begin
         s_r <= s_nxt;
      end
   end

   // Outputs, all from registered state
   assign dat_o = s_r.dat;
   assign ack_o = s_r.ack;
   assign source_select_o = s_r.cur;
   assign primary_mode_o = pmode;
   assign pll_enable_o = uses_pll(s_r.cur);
   assign switching_o = (s_r.fsm == ST_SWITCH);
   // Secondary stays powered while it runs the system clock
   assign secondary_enable_o = s_r.sec_en | (s_r.cur == SRC_SECONDARY);
   assign secondary_high_power_o = s_r.drive & s_r.cfg[CFG_SECSRC_BIT];
   assign ext_range_high_o = (s_r.cfg[CFG_RANGE_LO +: 2] == RANGE_ABOVE_8MHZ);
   assign monitor_enable_o = monitor_on;
   assign rc_trim_o = s_r.tune;

   // Checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_reset_current: assert property (disable iff (1'b0) $past(rst_i) |-> s_r.cur == CUR_RESET)
      else $error("current source not zero after reset");
   a_power_on_load: assert property (s_r.fsm == ST_POWERUP |=> s_r.cur == $past(s_r.init_src))
      else $error("power-on source not loaded");
   a_range_flag: assert property (ext_range_high_o == (s_r.cfg[4:3] == 2'h3))
      else $error("range flag wrong");
   a_switch_blocked: assert property (!switch_ok && s_r.fsm == ST_IDLE |=> s_r.fsm != ST_SWITCH)
      else $error("switch started while disabled");
   a_monitor_gate: assert property (monitor_enable_o == (s_r.cfg[7:6] == 2'h0))
      else $error("monitor enable wrong");
   a_switch_done: assert property (s_r.fsm == ST_IDLE && s_r.sw_req && switch_ok && combo_valid(s_r.req, pmode)
      |=> switching_o ##9 switching_o ##1 (s_r.cur == $past(s_r.req, 11)) && !s_r.sw_req)
      else $error("switch did not complete in time");
   a_lock_low: assert property ((switching_o || !pll_enable_o) |-> !s_r.lock)
      else $error("lock high during switch or non-PLL mode");
   a_fail_sticky: assert property (s_r.fail_sync && monitor_on |=> s_r.fail)
      else $error("clock fail not flagged");
   a_freeze_hold: assert property (frozen && wr_ctrl |=> $stable(s_r.req))
      else $error("request changed while frozen");
   a_drive_masked: assert property (!s_r.cfg[5] |-> !secondary_high_power_o)
      else $error("drive strength active with digital input");
   // Drive bit reaches the pin only with a crystal secondary
   a_drive_pass: assert property (s_r.cfg[CFG_SECSRC_BIT] |-> secondary_high_power_o == s_r.drive)
      else $error("drive strength not passed to crystal");

   // Bus handshake: one wait state, ack never held two cycles
   a_ack_latency: assert property (bus_req && !ack_o |=> ack_o)
      else $error("ack missing one cycle after request");
   a_ack_pulse: assert property (ack_o |=> !ack_o)
      else $error("ack held for two cycles");
   a_data_upper: assert property (dat_o[31:16] == 16'h0000)
      else $error("upper read data not zero");

   // Configuration is captured in reset and never moves afterwards
   a_cfg_hold: assert property ($stable(s_r.cfg) && $stable(s_r.init_src))
      else $error("configuration changed outside reset");
   // Power-up lasts a single cycle before the sequencer idles
   a_power_to_idle: assert property (s_r.fsm == ST_POWERUP |=> s_r.fsm == ST_IDLE)
      else $error("power-up state not left");

   // A granted request enters the switch state on the next edge
   a_switch_entry: assert property (s_r.fsm == ST_IDLE && s_r.sw_req && switch_ok && combo_valid(s_r.req, pmode)
      |=> switching_o)
      else $error("granted switch not started");
   // Lock drops on the edge that starts a switch
   a_lock_clear_switch: assert property (s_r.fsm == ST_IDLE && s_r.sw_req && switch_ok
      && combo_valid(s_r.req, pmode) |=> !s_r.lock)
      else $error("lock not cleared at switch start");
   // Settle counter steps by one, so a switch can never run long
   a_settle_bound: assert property (switching_o |-> s_r.settle < SWITCH_SETTLE_CYCLES)
      else $error("settle count out of range");
   a_settle_step: assert property (switching_o && s_r.settle != SWITCH_SETTLE_CYCLES - 4'h1
      |=> switching_o && s_r.settle == $past(s_r.settle) + 4'h1)
      else $error("settle count did not advance");
   // Refused requests clear at once and leave the source alone
   a_switch_refused: assert property (s_r.fsm == ST_IDLE && s_r.sw_req
      && !(switch_ok && combo_valid(s_r.req, pmode)) |=> !s_r.sw_req && $stable(s_r.cur))
      else $error("refused switch not dropped");
   // While idle the current source never moves
   a_current_hold: assert property (s_r.fsm == ST_IDLE |=> $stable(s_r.cur))
      else $error("current source moved while idle");
   // With switching disabled no request can ever be pending
   a_request_idle: assert property (!switch_ok |-> !s_r.sw_req)
      else $error("switch request pending while disabled");

   // A frozen register takes no new switch request
   a_freeze_go: assert property (frozen && wr_ctrl && !s_r.sw_req |=> !s_r.sw_req)
      else $error("switch request accepted while frozen");
   // Software cannot clear freeze; only a disabled monitor can
   a_freeze_set_only: assert property (s_r.freeze && monitor_on |=> s_r.freeze)
      else $error("freeze cleared while monitor on");
   a_freeze_no_self_set: assert property (!s_r.freeze
      && !(wr_ctrl && sel_i[0] && dat_i[FREEZE_BIT]) |=> !s_r.freeze)
      else $error("freeze set without a write");
   a_freeze_off: assert property (!monitor_on |-> !s_r.freeze)
      else $error("freeze held with monitor off");

   // Fail flag: a written one keeps it, only hardware sets it
   a_fail_write_one: assert property (s_r.fail && wr_ctrl && sel_i[0] && dat_i[FAIL_BIT] |=> s_r.fail)
      else $error("writing one cleared the fail flag");
   a_fail_hold: assert property (s_r.fail && !wr_ctrl |=> s_r.fail)
      else $error("fail flag lost without a write");
   a_fail_hw_only: assert property (!s_r.fail && !(s_r.fail_sync && monitor_on) |=> !s_r.fail)
      else $error("fail flag set without a failure");

   // Lock follows the synchronised input or the start-up timer
   a_lock_set: assert property (s_r.fsm == ST_IDLE && !s_r.sw_req && pll_enable_o
      && (s_r.pll_sync || s_r.pll_cnt == PLL_START_CYCLES) |=> s_r.lock)
      else $error("lock not shown when PLL ready");

   // Register writes land on the acknowledging edge
   a_request_write: assert property (wr_ctrl && sel_i[1] && !frozen |=> s_r.req == $past(dat_i[REQ_LO +: 3]))
      else $error("request field write lost");
   a_request_hold: assert property (!wr_ctrl |=> $stable(s_r.req))
      else $error("request field moved without a write");
   a_ctrl_hold: assert property (!wr_ctrl |=> $stable(s_r.drive) && $stable(s_r.sec_en))
      else $error("control bits moved without a write");
   a_trim_write: assert property (wr_tune && sel_i[0] |=> rc_trim_o == $past(dat_i[TUNE_WIDTH-1:0]))
      else $error("trim write lost");
   a_trim_hold: assert property (!wr_tune |=> $stable(rc_trim_o))
      else $error("trim moved without a write");

   // The secondary stays powered while it runs the clock
   a_secondary_on: assert property (source_select_o == SRC_SECONDARY |-> secondary_enable_o)
      else $error("secondary off while running the clock");

   c_switch: cover property (switching_o ##1 !switching_o);
   c_lock: cover property ($rose(s_r.lock));
   c_fail: cover property ($rose(s_r.fail));
   c_freeze: cover property ($rose(s_r.freeze));
   c_refused: cover property (s_r.sw_req ##1 !s_r.sw_req && !switching_o);
endmodule

// ### verif/oscillator_select_control_tb.sv
`timescale 1ns/1ns
module oscillator_select_control_tb;
   import osc_select_pkg::*;
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin error_cnt++; \
   $display("[FAIL] %s expected %0h seen %0h", nm, ex, got); end end
   logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
   logic [3:0] adr_i = 4'h0, sel_i = 4'h0;
   logic [31:0] dat_i = 32'h0, dat_o;
   logic ack_o, pll_locked_i = 1'b0, clock_fail_i = 1'b0;
   logic [7:0] cfg_osc_i = 8'hff;
   logic [2:0] initial_source_cfg_i = 3'h7, source_select_o;
   logic [1:0] primary_mode_o;
   logic pll_enable_o, switching_o, secondary_enable_o, secondary_high_power_o;
   logic ext_range_high_o, monitor_enable_o;
   logic [TUNE_WIDTH-1:0] rc_trim_o;
   int error_cnt = 0, comparisons = 0;
   logic [15:0] q;
   // Short PLL start-up count keeps the lock scenario brief
   oscillator_select_control #(.PLL_START_CYCLES(16'h0014)) i_oscillator_select_control (.clk_i(clk_i),
      .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
      .dat_o(dat_o), .ack_o(ack_o), .cfg_osc_i(cfg_osc_i), .initial_source_cfg_i(initial_source_cfg_i),
      .pll_locked_i(pll_locked_i), .clock_fail_i(clock_fail_i), .source_select_o(source_select_o),
      .primary_mode_o(primary_mode_o), .pll_enable_o(pll_enable_o), .switching_o(switching_o),
      .secondary_enable_o(secondary_enable_o), .secondary_high_power_o(secondary_high_power_o),
      .ext_range_high_o(ext_range_high_o), .monitor_enable_o(monitor_enable_o), .rc_trim_o(rc_trim_o));
   // 100 MHz clock
   initial begin
      forever #5 clk_i = ~clk_i;
   end
   // One classic cycle; entered just after a rising edge, read data taken at the ack edge
   task automatic wb(input logic w, input logic [3:0] a, input logic [15:0] d);
      int n;
      n = 0;
      cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w; adr_i <= a; sel_i <= 4'h3; dat_i <= {16'h0000, d};
      do begin @(posedge clk_i); n++; end while (ack_o !== 1'b1 && n < 20);
      if (n >= 20) error_cnt++;
      q = dat_o[15:0];
      cyc_i <= 1'b0; stb_i <= 1'b0; we_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic rd(input logic [3:0] a, input logic [15:0] e, input string nm);
      wb(1'b0, a, 16'h0000);
      `CHK(nm, e, q)
   endtask
   // Configuration is only captured while reset is held
   task automatic do_reset(input logic [7:0] cfg, input logic [2:0] init);
      rst_i <= 1'b1; cfg_osc_i <= cfg; initial_source_cfg_i <= init;
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (3) @(posedge clk_i);
   endtask
   // Erased configuration: boot source, range, switching refused, trim register
   task automatic t_erased();
      do_reset(8'hff, 3'h7);
      `CHK("boot source", 3'h7, source_select_o)
      `CHK("boot pmode", 2'h3, primary_mode_o)
      `CHK("range high", 1'b1, ext_range_high_o)
      `CHK("monitor off", 1'b0, monitor_enable_o)
      rd(ADDR_OSC_CTRL, 16'h7700, "ctrl reset");
      rd(ADDR_CFG_VIEW, 16'h07ff, "cfg view");
      rd(4'hc, 16'h0000, "unmapped");
      wb(1'b1, ADDR_OSC_CTRL, 16'h0001);
      repeat (14) @(posedge clk_i);
      `CHK("no switch", 3'h7, source_select_o)
      rd(ADDR_OSC_CTRL, 16'h7000, "ctrl no switch");
      wb(1'b1, ADDR_RC_TUNE, 16'h002a);
      rd(ADDR_RC_TUNE, 16'h002a, "trim");
      `CHK("trim out", 6'h2a, rc_trim_o)
   endtask
   // Monitor on: switch with PLL, lock, fail flag, freeze
   task automatic t_monitor();
      do_reset(8'h3f, 3'h0);
      `CHK("monitor on", 1'b1, monitor_enable_o)
      wb(1'b1, ADDR_OSC_CTRL, 16'h0101);
      @(posedge clk_i);
      `CHK("switching", 1'b1, switching_o)
      repeat (14) @(posedge clk_i);
      `CHK("pll source", 3'h1, source_select_o)
      `CHK("pll enable", 1'b1, pll_enable_o)
      repeat (30) @(posedge clk_i);
      rd(ADDR_OSC_CTRL, 16'h1120, "pll lock");
      wb(1'b1, ADDR_OSC_CTRL, 16'h0001);
      repeat (14) @(posedge clk_i);
      rd(ADDR_OSC_CTRL, 16'h0000, "no pll");
      clock_fail_i <= 1'b1;
      repeat (5) @(posedge clk_i);
      clock_fail_i <= 1'b0;
      rd(ADDR_OSC_CTRL, 16'h0008, "fail set");
      wb(1'b1, ADDR_OSC_CTRL, 16'h0008);
      rd(ADDR_OSC_CTRL, 16'h0008, "fail write one");
      wb(1'b1, ADDR_OSC_CTRL, 16'h0000);
      rd(ADDR_OSC_CTRL, 16'h0000, "fail cleared");
      wb(1'b1, ADDR_OSC_CTRL, 16'h0086);
      rd(ADDR_OSC_CTRL, 16'h0086, "freeze set");
      `CHK("high power", 1'b1, secondary_high_power_o)
      wb(1'b1, ADDR_OSC_CTRL, 16'h0507);
      repeat (14) @(posedge clk_i);
      `CHK("frozen source", 3'h0, source_select_o)
      rd(ADDR_OSC_CTRL, 16'h0086, "frozen ctrl");
   endtask
   // Monitor off, external primary mode: decode table, drive ignored
   task automatic t_external();
      logic [2:0] cd [4];
      logic [2:0] ex [4];
      cd = '{3'h4, 3'h3, 3'h2, 3'h5};
      ex = '{3'h4, 3'h3, 3'h2, 3'h2};
      do_reset(8'h40, 3'h2);
      `CHK("range low", 1'b0, ext_range_high_o)
      wb(1'b1, ADDR_OSC_CTRL, 16'h0004);
      `CHK("drive ignored", 1'b0, secondary_high_power_o)
      for (int i = 0; i < 4; i++) begin
         wb(1'b1, ADDR_OSC_CTRL, {5'h00, cd[i], 8'h81});
         repeat (14) @(posedge clk_i);
         `CHK("ext source", ex[i], source_select_o)
         if (i == 0) `CHK("sec enable", 1'b1, secondary_enable_o)
      end
   endtask
   task automatic print_verdict();
      $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // Main sequence
   initial begin
      repeat (1) @(posedge clk_i);
      t_erased();
      t_monitor();
      t_external();
      print_verdict();
   end
   // Watchdog: whole run needs well under 1000 cycles
   initial begin
      repeat (5000) @(posedge clk_i);
      error_cnt++;
      print_verdict();
   end
endmodule
